// [include/prescale_pkg.sv]
// package: register map, field layout, reset values and type carriers for the prescale timer
package prescale_pkg;

   // register offsets (plain port, word addressed)
   localparam logic [3:0] CONTROL_OFFSET     = 4'h0;
   localparam logic [3:0] FIRST_COUNT_OFFSET = 4'h1;
   localparam logic [3:0] SECOND_COUNT_OFFSET = 4'h2;
   localparam logic [3:0] VECTOR_OFFSET      = 4'h3;

   // control register field positions
   localparam int SOURCE_MSB   = 15;
   localparam int SOURCE_LSB   = 14;
   localparam int RATIO_MSB    = 13;
   localparam int RATIO_LSB    = 11;
   localparam int HOLD_BIT     = 8;
   localparam int INTERVAL_MSB = 4;
   localparam int INTERVAL_LSB = 2;
   localparam int IRQ_EN_BIT   = 1;
   localparam int IRQ_FLAG_BIT = 0;

   // reset values
   localparam logic [1:0] SOURCE_RESET   = 2'h0;
   localparam logic [2:0] RATIO_RESET    = 3'h0;
   localparam logic       HOLD_RESET     = 1'b1;
   localparam logic [2:0] INTERVAL_RESET = 3'h0;
   localparam logic       IRQ_EN_RESET   = 1'b0;
   localparam logic       IRQ_FLAG_RESET = 1'b0;
   localparam logic [7:0] COUNT_RESET    = 8'h00;

   // fixed ratios while calendar mode is on
   localparam logic [2:0] CAL_FIRST_TAP  = 3'h7;
   localparam logic [2:0] CAL_SECOND_TAP = 3'h6;

   // source codes
   localparam logic [1:0] SRC_AUX     = 2'h0;
   localparam logic [1:0] SRC_SUBMAIN = 2'h1;

   // interrupt vector value of this source
   localparam logic [15:0] VECTOR_SECOND = 16'h000A;
   localparam logic [15:0] VECTOR_NONE   = 16'h0000;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_type;

   typedef struct packed {
      logic [1:0] source;
      logic [2:0] ratio;
      logic       hold;
      logic [2:0] interval;
      logic       irq_en;
   } control_type;

endpackage

// [verilog/clock_edge_detect.sv]
// synchroniser and rising edge detector for an outside clock input
`timescale 1ns/100ps
module clock_edge_detect (
   // clock and reset
   input  wire logic mclk,
   input  wire logic resetn,
   // outside clock level and its rising edge
   input  wire logic clk_in,
   output logic      rise
);
   logic meta_ff;
   logic sync_ff;
   logic last_ff;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         last_ff <= 1'b0;
      end else begin
         meta_ff <= clk_in;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
      end
   end

   assign rise = sync_ff & ~last_ff;
endmodule

// [verilog/divider_counter.sv]
// 8-bit prescale counter with software load and divided tap strobes
`timescale 1ns/100ps
module divider_counter #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             resetn,
   // counting
   input  wire logic             tick,
   input  wire logic             run,
   input  wire logic             clear,
   // software load
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] load_value,
   // state and tap strobes
   output logic      [WIDTH-1:0] count,
   output logic      [WIDTH-1:0] tap_pulse
);
   logic [WIDTH-1:0] count_ff;
   logic [WIDTH-1:0] nxt_count;

   // the reset constant and the tap list only cover up to eight bits
   if (WIDTH < 1 || WIDTH > 8) begin
      $error("divider_counter: WIDTH must be 1 to 8");
   end

   assign nxt_count = count_ff + WIDTH'(1);

   // load wins over a count tick in the same cycle
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         count_ff <= prescale_pkg::COUNT_RESET[WIDTH-1:0];
      end else if (clear) begin
         count_ff <= prescale_pkg::COUNT_RESET[WIDTH-1:0];
      end else if (load) begin
         count_ff <= load_value;
      end else if (tick && run) begin
         count_ff <= nxt_count;
      end
   end

   // bit i falls 1->0 once every 2^(i+1) ticks: that is the /2^(i+1) tap
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         tap_pulse[i] = tick & run & ~clear & ~load & count_ff[i] & ~nxt_count[i];
      end
   end

   assign count = count_ff;
endmodule

// [verilog/rtc_prescale_timer.sv]
// second prescale divider with control register and both prescale count registers
//
// What this block does
// - A two-bit source field picks the second divider clock: 00 aux, 01 submain, 1x first output.
// - In calendar mode the second divider always runs from the first divider output.
// - A three-bit ratio field picks the output ratio from /2 at code 0 to /256 at code 7.
// - In calendar mode the first output is fixed at /256 and the second at /128.
// - The second divider is frozen while its hold bit is 1, and hold resets to 1.
// - In calendar mode the hold bit is ignored and only the module clock hold stops it.
// - A three-bit interval field picks which tap, /2 to /256, sets the interval flag.
// - A read-write interrupt enable bit exists and resets to 0.
// - The interval flag is set by the selected event, is read-write, and resets to 0.
// - Reserved control bits 10-9 and 7-5 read as 0 and ignore writes.
// - The first divider 8-bit count is readable and writable by software.
// - The second divider 8-bit count is readable and writable by software.
// - A pending interval flag shows as vector value 0Ah below the higher sources.
// - A one-bit field picks the first divider input: 0 aux, 1 submain, outside calendar mode.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/100ps
module rtc_prescale_timer (
   // clock and reset
   input  wire logic                      mclk,
   input  wire logic                      resetn,
   // register port
   input  wire prescale_pkg::bus_req_type bus_req,
   output logic [15:0]                    rdata,
   // outside clocks
   input  wire logic                      aux_clock,
   input  wire logic                      submain_clock,
   // settings and state of the rest of the unit
   input  wire logic                      calendar_mode,
   input  wire logic                      module_clock_hold,
   input  wire logic                      first_divider_source_select,
   input  wire logic [2:0]                first_divider_ratio,
   input  wire logic                      first_divider_hold,
   input  wire logic                      higher_irq_pending,
   // outputs
   output logic                           first_divider_out,
   output logic                           second_divider_out,
   output logic                           irq_request,
   output logic [15:0]                    irq_vector_value
);
   prescale_pkg::control_type ctrl_ff;
   logic        irq_flag_ff;
   logic [15:0] rdata_ff;
   logic        first_out_ff;
   logic        second_out_ff;
   logic        irq_ff;
   logic [15:0] vector_ff;
   logic        calendar_last_ff;
   logic        aux_rise;
   logic        sub_rise;
   logic        first_tick;
   logic        first_run;
   logic        second_tick;
   logic        second_run;
   logic        clear_counts;
   logic [7:0]  first_count;
   logic [7:0]  second_count;
   logic [7:0]  first_taps;
   logic [7:0]  second_taps;
   logic [2:0]  first_sel;
   logic [2:0]  second_sel;
   logic        first_pulse;
   logic        second_pulse;
   logic        interval_event;
   logic        wr_ctrl;
   logic        wr_first;
   logic        wr_second;

   assign wr_ctrl   = bus_req.wr && bus_req.addr == prescale_pkg::CONTROL_OFFSET;
   assign wr_first  = bus_req.wr && bus_req.addr == prescale_pkg::FIRST_COUNT_OFFSET;
   assign wr_second = bus_req.wr && bus_req.addr == prescale_pkg::SECOND_COUNT_OFFSET;

   clock_edge_detect u_aux_edge (
      .mclk   (mclk),
      .resetn (resetn),
      .clk_in (aux_clock),
      .rise   (aux_rise)
   );

   clock_edge_detect u_sub_edge (
      .mclk   (mclk),
      .resetn (resetn),
      .clk_in (submain_clock),
      .rise   (sub_rise)
   );

   // leaving calendar mode resets both prescale counts
   assign clear_counts = calendar_last_ff & ~calendar_mode;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         calendar_last_ff <= 1'b0;
      end else begin
         calendar_last_ff <= calendar_mode;
      end
   end

   // first divider: source and hold live outside this block
   always_comb begin
      if (calendar_mode) begin
         first_tick = aux_rise;
         first_run  = ~module_clock_hold;
         first_sel  = prescale_pkg::CAL_FIRST_TAP;
      end else begin
         first_tick = first_divider_source_select ? sub_rise : aux_rise;
         first_run  = ~first_divider_hold;
         first_sel  = first_divider_ratio;
      end
   end

   divider_counter #(.WIDTH(8)) u_first (
      .mclk       (mclk),
      .resetn     (resetn),
      .tick       (first_tick),
      .run        (first_run),
      .clear      (clear_counts),
      .load       (wr_first),
      .load_value (bus_req.wdata[7:0]),
      .count      (first_count),
      .tap_pulse  (first_taps)
   );

   assign first_pulse = first_taps[first_sel];

   always_comb begin
      if (calendar_mode) begin
         second_tick = first_pulse;
         second_run  = ~module_clock_hold;
         second_sel  = prescale_pkg::CAL_SECOND_TAP;
      end else begin
         case (ctrl_ff.source)
            prescale_pkg::SRC_AUX:     second_tick = aux_rise;
            prescale_pkg::SRC_SUBMAIN: second_tick = sub_rise;
            default:                   second_tick = first_pulse;
         endcase
         second_run = ~ctrl_ff.hold;
         second_sel = ctrl_ff.ratio;
      end
   end

   divider_counter #(.WIDTH(8)) u_second (
      .mclk       (mclk),
      .resetn     (resetn),
      .tick       (second_tick),
      .run        (second_run),
      .clear      (clear_counts),
      .load       (wr_second),
      .load_value (bus_req.wdata[7:0]),
      .count      (second_count),
      .tap_pulse  (second_taps)
   );

   assign second_pulse   = second_taps[second_sel];
   assign interval_event = second_taps[ctrl_ff.interval];

   // control fields; reserved bits are simply not stored
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ctrl_ff.source   <= prescale_pkg::SOURCE_RESET;
         ctrl_ff.ratio    <= prescale_pkg::RATIO_RESET;
         ctrl_ff.hold     <= prescale_pkg::HOLD_RESET;
         ctrl_ff.interval <= prescale_pkg::INTERVAL_RESET;
         ctrl_ff.irq_en   <= prescale_pkg::IRQ_EN_RESET;
      end else if (wr_ctrl) begin
         ctrl_ff.source   <= bus_req.wdata[prescale_pkg::SOURCE_MSB:prescale_pkg::SOURCE_LSB];
         ctrl_ff.ratio    <= bus_req.wdata[prescale_pkg::RATIO_MSB:prescale_pkg::RATIO_LSB];
         ctrl_ff.hold     <= bus_req.wdata[prescale_pkg::HOLD_BIT];
         ctrl_ff.interval <= bus_req.wdata[prescale_pkg::INTERVAL_MSB:prescale_pkg::INTERVAL_LSB];
         ctrl_ff.irq_en   <= bus_req.wdata[prescale_pkg::IRQ_EN_BIT];
      end
   end

   // an event in the cycle of a software write wins
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irq_flag_ff <= prescale_pkg::IRQ_FLAG_RESET;
      end else if (interval_event) begin
         irq_flag_ff <= 1'b1;
      end else if (wr_ctrl) begin
         irq_flag_ff <= bus_req.wdata[prescale_pkg::IRQ_FLAG_BIT];
      end
   end

   function automatic logic [15:0] control_word(input prescale_pkg::control_type c,
                                                input logic flag);
      logic [15:0] w;
      w = 16'h0000;
      w[prescale_pkg::SOURCE_MSB:prescale_pkg::SOURCE_LSB]     = c.source;
      w[prescale_pkg::RATIO_MSB:prescale_pkg::RATIO_LSB]       = c.ratio;
      w[prescale_pkg::HOLD_BIT]                                = c.hold;
      w[prescale_pkg::INTERVAL_MSB:prescale_pkg::INTERVAL_LSB] = c.interval;
      w[prescale_pkg::IRQ_EN_BIT]                              = c.irq_en;
      w[prescale_pkg::IRQ_FLAG_BIT]                            = flag;
      return w;
   endfunction

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdata_ff <= 16'h0000;
      end else if (bus_req.rd) begin
         case (bus_req.addr)
            prescale_pkg::CONTROL_OFFSET:      rdata_ff <= control_word(ctrl_ff, irq_flag_ff);
            prescale_pkg::FIRST_COUNT_OFFSET:  rdata_ff <= {8'h00, first_count};
            prescale_pkg::SECOND_COUNT_OFFSET: rdata_ff <= {8'h00, second_count};
            prescale_pkg::VECTOR_OFFSET:       rdata_ff <= vector_ff;
            default:                           rdata_ff <= 16'h0000;
         endcase
      end else begin
         rdata_ff <= 16'h0000;
      end
   end

   // divided clocks toggle on each selected tap strobe
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         first_out_ff  <= 1'b0;
         second_out_ff <= 1'b0;
      end else begin
         first_out_ff  <= first_out_ff ^ first_pulse;
         second_out_ff <= second_out_ff ^ second_pulse;
      end
   end

   // higher-ranked sources mask this vector value
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irq_ff    <= 1'b0;
         vector_ff <= prescale_pkg::VECTOR_NONE;
      end else begin
         irq_ff    <= irq_flag_ff & ctrl_ff.irq_en;
         vector_ff <= (irq_flag_ff && !higher_irq_pending) ? prescale_pkg::VECTOR_SECOND
                                                           : prescale_pkg::VECTOR_NONE;
      end
   end

   assign rdata              = rdata_ff;
   assign first_divider_out  = first_out_ff;
   assign second_divider_out = second_out_ff;
   assign irq_request        = irq_ff;
   assign irq_vector_value   = vector_ff;

   // watchers on the counting paths and the register side
   hold_default_a : assert property (@(posedge mclk) $rose(resetn)
      |-> ctrl_ff.hold && !ctrl_ff.irq_en && !irq_flag_ff)
      else $error("control reset values wrong");

   held_freeze_a : assert property (@(posedge mclk) disable iff (!resetn)
      (!calendar_mode && ctrl_ff.hold && !wr_second && !clear_counts)
      |=> $stable(second_count))
      else $error("second count moved while held");

   cal_hold_a : assert property (@(posedge mclk) disable iff (!resetn)
      (calendar_mode && module_clock_hold) |-> second_taps == 8'h00)
      else $error("second divider ran under module hold");

   flag_set_a : assert property (@(posedge mclk) disable iff (!resetn)
      interval_event |=> irq_flag_ff)
      else $error("interval event did not set flag");

   flag_write_a : assert property (@(posedge mclk) disable iff (!resetn)
      (wr_ctrl && !interval_event)
      |=> irq_flag_ff == $past(bus_req.wdata[0]))
      else $error("flag write lost");

   irq_pair_a : assert property (@(posedge mclk) disable iff (!resetn)
      irq_request |-> $past(irq_flag_ff) && $past(ctrl_ff.irq_en))
      else $error("request without flag and enable");

   irq_on_a : assert property (@(posedge mclk) disable iff (!resetn)
      (irq_flag_ff && ctrl_ff.irq_en) |=> irq_request)
      else $error("request missing with flag and enable");

   reserved_zero_a : assert property (@(posedge mclk) disable iff (!resetn)
      (bus_req.rd && bus_req.addr == prescale_pkg::CONTROL_OFFSET)
      |=> (rdata & 16'h06E0) == 16'h0000)
      else $error("reserved bits read non-zero");

   count_load_a : assert property (@(posedge mclk) disable iff (!resetn)
      (wr_first && !clear_counts) |=> first_count == $past(bus_req.wdata[7:0]))
      else $error("first count write lost");

   first_hold_a : assert property (@(posedge mclk) disable iff (!resetn)
      (!calendar_mode && first_divider_hold && !wr_first && !clear_counts)
      |=> $stable(first_count))
      else $error("first count moved while held");

   first_source_a : assert property (@(posedge mclk) disable iff (!resetn)
      (!calendar_mode && !first_divider_source_select) |-> first_tick == aux_rise)
      else $error("first divider not on aux clock");

   second_source_a : assert property (@(posedge mclk) disable iff (!resetn)
      (!calendar_mode && ctrl_ff.source == prescale_pkg::SRC_SUBMAIN)
      |-> second_tick == sub_rise)
      else $error("second divider not on submain clock");

   vector_value_a : assert property (@(posedge mclk) disable iff (!resetn)
      (irq_flag_ff && !higher_irq_pending) |=> irq_vector_value == 16'h000A)
      else $error("vector value not 0Ah");

   cal_source_a : assert property (@(posedge mclk) disable iff (!resetn)
      calendar_mode |-> second_tick == first_pulse)
      else $error("calendar mode source wrong");

   cal_first_tap_a : assert property (@(posedge mclk) disable iff (!resetn)
      calendar_mode |-> first_pulse == first_taps[7])
      else $error("calendar first tap not the top tap");

   out_toggle_a : assert property (@(posedge mclk) disable iff (!resetn)
      second_pulse |=> second_divider_out != $past(second_divider_out))
      else $error("second output missed its tap");
endmodule

// [tb/testbench.sv]
// self-checking bench for the second prescale divider and its registers
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin err_total++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module testbench;
   logic                      mclk;
   logic                      resetn;
   prescale_pkg::bus_req_type bus_req;
   logic [15:0]               rdata;
   logic                      aux_clock;
   logic                      submain_clock;
   logic                      calendar_mode;
   logic                      module_clock_hold;
   logic                      first_divider_source_select;
   logic [2:0]                first_divider_ratio;
   logic                      first_divider_hold;
   logic                      higher_irq_pending;
   logic                      first_divider_out;
   logic                      second_divider_out;
   logic                      irq_request;
   logic [15:0]               irq_vector_value;
   int                        err_total;
   int                        compares;
   logic [15:0]               d;
   logic                      o;
   logic                      p;

   rtc_prescale_timer u_dut (
      .mclk                        (mclk),
      .resetn                      (resetn),
      .bus_req                     (bus_req),
      .rdata                       (rdata),
      .aux_clock                   (aux_clock),
      .submain_clock               (submain_clock),
      .calendar_mode               (calendar_mode),
      .module_clock_hold           (module_clock_hold),
      .first_divider_source_select (first_divider_source_select),
      .first_divider_ratio         (first_divider_ratio),
      .first_divider_hold          (first_divider_hold),
      .higher_irq_pending          (higher_irq_pending),
      .first_divider_out           (first_divider_out),
      .second_divider_out          (second_divider_out),
      .irq_request                 (irq_request),
      .irq_vector_value            (irq_vector_value)
   );

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   function automatic logic [15:0] ctl(input logic [1:0] s, input logic [2:0] r, input logic h,
                                       input logic [2:0] iv, input logic en, input logic f);
      return {s, r, 2'h0, h, 3'h0, iv, en, f};
   endfunction

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge mclk);
      bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus_req.wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge mclk);
      bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus_req.rd <= 1'b0;
      @(posedge mclk);
      v = rdata;
   endtask

   // outside clocks stay slower than half mclk, then the synchroniser settles
   task automatic pulses(input int na, input int ns);
      repeat (na) begin
         @(posedge mclk);
         aux_clock <= 1'b1;
         repeat (4) @(posedge mclk);
         aux_clock <= 1'b0;
         repeat (3) @(posedge mclk);
      end
      repeat (ns) begin
         @(posedge mclk);
         submain_clock <= 1'b1;
         repeat (4) @(posedge mclk);
         submain_clock <= 1'b0;
         repeat (3) @(posedge mclk);
      end
      repeat (6) @(posedge mclk);
   endtask

   task automatic test_reset_and_map();
      rd(prescale_pkg::CONTROL_OFFSET, d);
      `CHK("control reset", 16'h0100, d)
      `CHK("irq enable reset", 1'b0, d[1])
      `CHK("flag reset", 1'b0, d[0])
      wr(prescale_pkg::CONTROL_OFFSET, 16'hFFFF);
      rd(prescale_pkg::CONTROL_OFFSET, d);
      `CHK("control reserved", 16'hF91F, d)
      wr(4'hF, 16'h0000);
      rd(4'hF, d);
      `CHK("unmapped read", 16'h0000, d)
      rd(prescale_pkg::CONTROL_OFFSET, d);
      `CHK("control after unmapped write", 16'hF91F, d)
      repeat (2) @(posedge mclk);
      `CHK("irq with flag and enable", 1'b1, irq_request)
      wr(prescale_pkg::CONTROL_OFFSET, ctl(2'h0, 3'h0, 1'b1, 3'h0, 1'b0, 1'b1));
      rd(prescale_pkg::VECTOR_OFFSET, d);
      `CHK("vector value", 16'h000A, d)
      `CHK("vector port", 16'h000A, irq_vector_value)
      `CHK("irq without enable", 1'b0, irq_request)
      @(posedge mclk);
      higher_irq_pending <= 1'b1;
      repeat (2) @(posedge mclk);
      rd(prescale_pkg::VECTOR_OFFSET, d);
      `CHK("vector under higher source", 16'h0000, d)
      higher_irq_pending <= 1'b0;
      wr(prescale_pkg::CONTROL_OFFSET, ctl(2'h0, 3'h0, 1'b1, 3'h0, 1'b0, 1'b0));
      wr(prescale_pkg::FIRST_COUNT_OFFSET, 16'hFF5A);
      wr(prescale_pkg::SECOND_COUNT_OFFSET, 16'h12A5);
      pulses(3, 3);
      rd(prescale_pkg::FIRST_COUNT_OFFSET, d);
      `CHK("first count rw", 16'h005A, d)
      rd(prescale_pkg::SECOND_COUNT_OFFSET, d);
      `CHK("second count held", 16'h00A5, d)
      $display("test reset_and_map done");
   endtask

   task automatic test_sources();
      logic [7:0] ex1 [4];
      logic [7:0] ex2 [4];
      ex1 = '{8'h03, 8'h08, 8'h08, 8'h03};
      ex2 = '{8'h08, 8'h03, 8'h04, 8'h01};
      first_divider_hold <= 1'b0;
      for (int s = 0; s < 4; s++) begin
         first_divider_source_select <= (s == 0 || s == 3);
         wr(prescale_pkg::FIRST_COUNT_OFFSET, 16'h0000);
         wr(prescale_pkg::SECOND_COUNT_OFFSET, 16'h0000);
         wr(prescale_pkg::CONTROL_OFFSET, ctl(2'(s), 3'h7, 1'b0, 3'h7, 1'b0, 1'b0));
         pulses(8, 3);
         rd(prescale_pkg::FIRST_COUNT_OFFSET, d);
         `CHK("first count by source", {8'h00, ex1[s]}, d)
         rd(prescale_pkg::SECOND_COUNT_OFFSET, d);
         `CHK("second count by source", {8'h00, ex2[s]}, d)
      end
      first_divider_hold <= 1'b1;
      $display("test sources done");
   endtask

   // only the chosen tap may toggle the output or raise the flag
   task automatic test_taps();
      for (int k = 0; k < 8; k++) begin
         wr(prescale_pkg::CONTROL_OFFSET, ctl(2'h0, 3'(k), 1'b0, 3'(k), 1'b1, 1'b0));
         wr(prescale_pkg::SECOND_COUNT_OFFSET, {8'h00, 8'((1 << k) - 1)});
         o = second_divider_out;
         pulses(1, 0);
         `CHK("output below tap", o, second_divider_out)
         rd(prescale_pkg::CONTROL_OFFSET, d);
         `CHK("flag below tap", 1'b0, d[0])
         wr(prescale_pkg::SECOND_COUNT_OFFSET, {8'h00, 8'((2 << k) - 1)});
         pulses(1, 0);
         `CHK("output at tap", ~o, second_divider_out)
         rd(prescale_pkg::CONTROL_OFFSET, d);
         `CHK("flag at tap", 1'b1, d[0])
         `CHK("irq at tap", 1'b1, irq_request)
      end
      $display("test taps done");
   endtask

   task automatic test_calendar();
      @(posedge mclk);
      calendar_mode <= 1'b1;
      first_divider_ratio <= 3'h0;
      first_divider_source_select <= 1'b1;
      wr(prescale_pkg::CONTROL_OFFSET, ctl(2'h1, 3'h7, 1'b1, 3'h0, 1'b0, 1'b0));
      wr(prescale_pkg::FIRST_COUNT_OFFSET, 16'h00FC);
      wr(prescale_pkg::SECOND_COUNT_OFFSET, 16'h007F);
      o = second_divider_out;
      p = first_divider_out;
      pulses(4, 2);
      rd(prescale_pkg::SECOND_COUNT_OFFSET, d);
      `CHK("calendar second count", 16'h0080, d)
      `CHK("calendar second output", ~o, second_divider_out)
      `CHK("calendar first output", ~p, first_divider_out)
      @(posedge mclk);
      module_clock_hold <= 1'b1;
      wr(prescale_pkg::FIRST_COUNT_OFFSET, 16'h00FC);
      pulses(4, 0);
      rd(prescale_pkg::FIRST_COUNT_OFFSET, d);
      `CHK("module hold first", 16'h00FC, d)
      rd(prescale_pkg::SECOND_COUNT_OFFSET, d);
      `CHK("module hold second", 16'h0080, d)
      module_clock_hold <= 1'b0;
      calendar_mode <= 1'b0;
      repeat (2) @(posedge mclk);
      rd(prescale_pkg::SECOND_COUNT_OFFSET, d);
      `CHK("count cleared leaving calendar", 16'h0000, d)
      $display("test calendar done");
   endtask

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // a full run takes about 1000 cycles
   initial begin
      repeat (20000) @(posedge mclk);
      err_total++;
      report_and_stop();
   end

   initial begin
      err_total = 0;
      compares = 0;
      resetn = 1'b0;
      bus_req = '0;
      aux_clock = 1'b0;
      submain_clock = 1'b0;
      calendar_mode = 1'b0;
      module_clock_hold = 1'b0;
      first_divider_source_select = 1'b0;
      first_divider_ratio = 3'h0;
      first_divider_hold = 1'b1;
      higher_irq_pending = 1'b0;
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      test_reset_and_map();
      test_sources();
      test_taps();
      test_calendar();
      report_and_stop();
   end
endmodule
